// >>> src/amr_pkg.sv
/*
 constants, encodings and state layout of the atomic read-modify-write unit.
 assumes one 64-bit load/store path and an apb register slave.
*/
package amr_pkg;
  // --------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_INSTR = 12'h004;
  localparam logic [11:0] A_OPLO = 12'h008;
  localparam logic [11:0] A_OPHI = 12'h00C;
  localparam logic [11:0] A_BSLO = 12'h010;
  localparam logic [11:0] A_BSHI = 12'h014;
  localparam logic [11:0] A_SPLO = 12'h018;
  localparam logic [11:0] A_SPHI = 12'h01C;
  localparam logic [11:0] A_STAT = 12'h020;
  localparam logic [11:0] A_DLO = 12'h024;
  localparam logic [11:0] A_DHI = 12'h028;
  // --------------------------------------------------------------
  // instruction fields
  // --------------------------------------------------------------
  localparam int F_SIZE = 30;
  localparam int F_ACQ = 23;
  localparam int F_REL = 22;
  localparam int F_ONE = 21;
  localparam int F_OPND = 16;
  localparam int F_OPMSB = 15;
  localparam int F_OPC = 12;
  localparam int F_BASE = 5;
  localparam int F_DEST = 0;
  localparam logic [5:0] FIX_HI = 6'h38;
  localparam logic [4:0] IDX_31 = 5'h1F;
  localparam logic [3:0] SP_ALIGN = 4'h0;
  localparam logic [1:0] SZ_DW = 2'h3;
  // --------------------------------------------------------------
  // status bits
  // --------------------------------------------------------------
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_UNDEF = 2;
  localparam int S_FAULT = 3;
  localparam int S_ALIGN = 4;
  localparam int S_LDORD = 5;
  localparam int S_STORD = 6;
  localparam int S_DIDX = 8;
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    op_add = 4'h0, op_bit_clear = 4'h1, op_xor = 4'h2, op_or = 4'h3,
    op_signed_max = 4'h4, op_signed_min = 4'h5,
    op_unsigned_max = 4'h6, op_unsigned_min = 4'h7, op_swap = 4'h8
  } amr_op_t;
  typedef enum logic [1:0] {
    st_idle = 2'h0, st_read = 2'h1, st_write = 2'h3
  } amr_state_t;
  typedef struct packed {
    amr_state_t st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ext_dis;
    logic [31:0] instr;
    logic [63:0] opnd;
    logic [63:0] base;
    logic [63:0] sp;
    logic [63:0] dest;
    logic [63:0] data;
    logic busy;
    logic done;
    logic undef;
    logic fault;
    logic align;
    logic ld_ord;
    logic st_ord;
    logic mem_req;
    logic mem_wr;
    logic mem_ord;
    logic mem_lock;
    logic [1:0] mem_size;
    logic [63:0] mem_addr;
    logic [63:0] mem_wdata;
  } amr_regs_t;
endpackage : amr_pkg

// >>> src/amr_unit.sv
/*
 atomic read-modify-write unit: apb register slave, decoder, alu and
 locked read-then-write sequencer on the load/store port.
 assumes mem_* inputs come from logic on mclk; ack is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module amr_unit (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_wr,
  output logic mem_ord,
  output logic mem_lock,
  output logic [1:0] mem_size,
  output logic [63:0] mem_addr,
  output logic [63:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_fault,
  input wire logic [63:0] mem_rdata
);
  import amr_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] zx(input logic [63:0] v, input logic [1:0] s);
    case (s)
      2'h0: zx = {56'h0, v[7:0]};
      2'h1: zx = {48'h0, v[15:0]};
      2'h2: zx = {32'h0, v[31:0]};
      default: zx = v;
    endcase
  endfunction : zx

  function automatic logic [63:0] sx(input logic [63:0] v, input logic [1:0] s);
    case (s)
      2'h0: sx = {{56{v[7]}}, v[7:0]};
      2'h1: sx = {{48{v[15]}}, v[15:0]};
      2'h2: sx = {{32{v[31]}}, v[31:0]};
      default: sx = v;
    endcase
  endfunction : sx

  function automatic logic [63:0] alu(input amr_op_t op, input logic [1:0] s,
                                      input logic [63:0] m, input logic [63:0] v);
    logic [63:0] mz;
    logic [63:0] vz;
    logic sgt;
    logic ugt;
    logic [63:0] r;
    mz = zx(m, s);
    vz = zx(v, s);
    sgt = $signed(sx(m, s)) > $signed(sx(v, s));
    ugt = mz > vz;
    case (op)
      op_add: r = mz + vz;
      op_bit_clear: r = mz & ~vz;
      op_xor: r = mz ^ vz;
      op_or: r = mz | vz;
      op_signed_max: r = sgt ? mz : vz;
      op_signed_min: r = sgt ? vz : mz;
      op_unsigned_max: r = ugt ? mz : vz;
      op_unsigned_min: r = ugt ? vz : mz;
      op_swap: r = vz;
      default: r = mz;
    endcase
    alu = zx(r, s);
  endfunction : alu

  function automatic logic [63:0] wlo(input logic [63:0] o, input logic [31:0] d,
                                      input logic [3:0] b, input logic hi);
    logic [31:0] w;
    w = hi ? o[63:32] : o[31:0];
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        w[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    wlo = hi ? {w, o[31:0]} : {o[63:32], w};
  endfunction : wlo

  amr_regs_t r_reg;
  amr_regs_t r_next;

  // ----------------------------------------------------------------
  // decode of a written instruction word
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic hit;
  logic start;
  logic d_fix;
  logic d_legal;
  logic d_misal;
  logic [3:0] d_sel;
  logic [4:0] d_base;
  logic [4:0] d_dest;
  logic d_ldord;
  amr_op_t i_op;
  logic [1:0] i_sz;
  logic [31:0] stat;

  always_comb begin
    setup = psel & ~penable;
    access = psel & penable & r_reg.pready;
    hit = (paddr <= A_DHI) && (paddr[1:0] == 2'h0);
    start = access & pwrite & ~r_reg.pslverr & (paddr == A_INSTR) & ~r_reg.busy;
    d_sel = {pwdata[F_OPMSB], pwdata[F_OPC +: 3]};
    d_base = pwdata[F_BASE +: 5];
    d_dest = pwdata[F_DEST +: 5];
    d_fix = (pwdata[29:24] == FIX_HI) & pwdata[F_ONE] & (pwdata[11:10] == 2'h0);
    d_legal = ~r_reg.ext_dis & d_fix & (d_sel <= 4'h8);
    d_misal = (d_base == IDX_31) & (r_reg.sp[3:0] != SP_ALIGN);
    d_ldord = pwdata[F_ACQ] & (d_dest != IDX_31);
    i_op = amr_op_t'({r_reg.instr[F_OPMSB], r_reg.instr[F_OPC +: 3]});
    i_sz = r_reg.instr[F_SIZE +: 2];
    stat = '0;
    stat[S_BUSY] = r_reg.busy;
    stat[S_DONE] = r_reg.done;
    stat[S_UNDEF] = r_reg.undef;
    stat[S_FAULT] = r_reg.fault;
    stat[S_ALIGN] = r_reg.align;
    stat[S_LDORD] = r_reg.ld_ord;
    stat[S_STORD] = r_reg.st_ord;
    stat[S_DIDX +: 5] = r_reg.instr[F_DEST +: 5];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.pready = setup;
    if (setup) begin
      r_next.pslverr = ~hit;
      case (paddr)
        A_CTRL: r_next.prdata = {31'h0, ~r_reg.ext_dis};
        A_INSTR: r_next.prdata = r_reg.instr;
        A_OPLO: r_next.prdata = r_reg.opnd[31:0];
        A_OPHI: r_next.prdata = r_reg.opnd[63:32];
        A_BSLO: r_next.prdata = r_reg.base[31:0];
        A_BSHI: r_next.prdata = r_reg.base[63:32];
        A_SPLO: r_next.prdata = r_reg.sp[31:0];
        A_SPHI: r_next.prdata = r_reg.sp[63:32];
        A_STAT: r_next.prdata = stat;
        A_DLO: r_next.prdata = r_reg.dest[31:0];
        A_DHI: r_next.prdata = r_reg.dest[63:32];
        default: r_next.prdata = 32'h0;
      endcase
    end
    if (access & pwrite & ~r_reg.pslverr & ~r_reg.busy) begin
      case (paddr)
        A_CTRL: r_next.ext_dis = pstrb[0] ? ~pwdata[0] : r_reg.ext_dis;
        A_OPLO: r_next.opnd = wlo(r_reg.opnd, pwdata, pstrb, 1'b0);
        A_OPHI: r_next.opnd = wlo(r_reg.opnd, pwdata, pstrb, 1'b1);
        A_BSLO: r_next.base = wlo(r_reg.base, pwdata, pstrb, 1'b0);
        A_BSHI: r_next.base = wlo(r_reg.base, pwdata, pstrb, 1'b1);
        A_SPLO: r_next.sp = wlo(r_reg.sp, pwdata, pstrb, 1'b0);
        A_SPHI: r_next.sp = wlo(r_reg.sp, pwdata, pstrb, 1'b1);
        default: r_next.st = r_reg.st;
      endcase
    end
    case (r_reg.st)
      st_idle: begin
        if (start) begin
          r_next.instr = pwdata;
          r_next.done = 1'b0;
          r_next.undef = 1'b0;
          r_next.fault = 1'b0;
          r_next.align = 1'b0;
          r_next.ld_ord = d_ldord;
          r_next.st_ord = pwdata[F_REL];
          if (!d_legal) begin
            r_next.undef = 1'b1;
            r_next.done = 1'b1;
          end else if (d_misal) begin
            r_next.align = 1'b1;
            r_next.done = 1'b1;
          end else begin
            r_next.st = st_read;
            r_next.busy = 1'b1;
            r_next.mem_req = 1'b1;
            r_next.mem_wr = 1'b0;
            r_next.mem_lock = 1'b1;
            r_next.mem_ord = d_ldord;
            r_next.mem_size = pwdata[F_SIZE +: 2];
            r_next.mem_addr = (d_base == IDX_31) ? r_reg.sp : r_reg.base;
          end
        end
      end
      st_read: begin
        if (mem_ack) begin
          if (mem_fault) begin
            r_next.st = st_idle;
            r_next.busy = 1'b0;
            r_next.fault = 1'b1;
            r_next.done = 1'b1;
            r_next.mem_req = 1'b0;
            r_next.mem_lock = 1'b0;
          end else begin
            r_next.st = st_write;
            r_next.data = zx(mem_rdata, i_sz);
            r_next.mem_wr = 1'b1;
            r_next.mem_ord = r_reg.st_ord;
            r_next.mem_wdata = alu(i_op, i_sz, mem_rdata, r_reg.opnd);
          end
        end
      end
      st_write: begin
        if (mem_ack) begin
          r_next.st = st_idle;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.mem_req = 1'b0;
          r_next.mem_wr = 1'b0;
          r_next.mem_lock = 1'b0;
          if (mem_fault) begin
            r_next.fault = 1'b1;
          end else begin
            r_next.dest = r_reg.data;
          end
        end
      end
      default: r_next.st = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign mem_req = r_reg.mem_req;
  assign mem_wr = r_reg.mem_wr;
  assign mem_ord = r_reg.mem_ord;
  assign mem_lock = r_reg.mem_lock;
  assign mem_size = r_reg.mem_size;
  assign mem_addr = r_reg.mem_addr;
  assign mem_wdata = r_reg.mem_wdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic rd_ok;
  logic rd_bad;
  logic wr_ok;
  logic go;
  assign rd_ok = (r_reg.st == st_read) & mem_ack & ~mem_fault;
  assign rd_bad = (r_reg.st == st_read) & mem_ack & mem_fault;
  assign wr_ok = (r_reg.st == st_write) & mem_ack & ~mem_fault;
  assign go = start & d_legal & ~d_misal;

  property p_lock;
    @(posedge mclk) disable iff (!rst_n)
    rd_ok |=> mem_req && mem_wr && mem_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("lock dropped between read and write");

  property p_undef;
    @(posedge mclk) disable iff (!rst_n)
    start && (d_sel > 4'h8) |=> r_reg.undef && !mem_req ##1 !mem_req;
  endproperty
  a_undef: assert property (p_undef) else $error("bad selector made an access");

  property p_noext;
    @(posedge mclk) disable iff (!rst_n)
    start && r_reg.ext_dis |=> r_reg.undef && r_reg.done && !mem_req;
  endproperty
  a_noext: assert property (p_noext) else $error("disabled extension not undefined");

  property p_ldord;
    @(posedge mclk) disable iff (!rst_n)
    go |=> mem_ord == ($past(pwdata[F_ACQ]) && ($past(d_dest) != IDX_31));
  endproperty
  a_ldord: assert property (p_ldord) else $error("read ordering wrong");

  property p_stord;
    @(posedge mclk) disable iff (!rst_n)
    rd_ok |=> mem_ord == r_reg.instr[F_REL];
  endproperty
  a_stord: assert property (p_stord) else $error("write ordering wrong");

  property p_swap;
    @(posedge mclk) disable iff (!rst_n)
    rd_ok && (i_op == op_swap) |=> mem_wdata == zx(r_reg.opnd, i_sz);
  endproperty
  a_swap: assert property (p_swap) else $error("swap data wrong");

  property p_abort;
    @(posedge mclk) disable iff (!rst_n)
    rd_bad |=> !mem_req && r_reg.fault && (r_reg.dest == $past(r_reg.dest));
  endproperty
  a_abort: assert property (p_abort) else $error("faulted read not aborted");

  property p_dest;
    @(posedge mclk) disable iff (!rst_n)
    wr_ok |=> r_reg.done && !mem_lock && (r_reg.dest == $past(r_reg.data));
  endproperty
  a_dest: assert property (p_dest) else $error("destination not old value");

  property p_sp;
    @(posedge mclk) disable iff (!rst_n)
    go && (d_base == IDX_31) |=> mem_addr == $past(r_reg.sp);
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer not used");

  property p_narrow;
    @(posedge mclk) disable iff (!rst_n)
    wr_ok && (i_sz != SZ_DW) |=> r_reg.dest[63:32] == 32'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow result not zero-extended");

  property p_size;
    @(posedge mclk) disable iff (!rst_n)
    go |=> mem_size == $past(pwdata[F_SIZE +: 2]);
  endproperty
  a_size: assert property (p_size) else $error("access size not from size field");

  property p_rdreq;
    @(posedge mclk) disable iff (!rst_n)
    go |=> mem_req && !mem_wr && mem_lock;
  endproperty
  a_rdreq: assert property (p_rdreq) else $error("locked read not issued");

  // a pending request must not move under the memory side
  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
    mem_req && !mem_ack |=> mem_req && $stable(mem_wr) && $stable(mem_addr) &&
      $stable(mem_size) && $stable(mem_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");

  c_swap: cover property (@(posedge mclk) disable iff (!rst_n) wr_ok && i_op == op_swap);
  c_fault: cover property (@(posedge mclk) disable iff (!rst_n) rd_bad);
  c_undef: cover property (@(posedge mclk) disable iff (!rst_n) start && !d_legal);
  c_smin: cover property (@(posedge mclk) disable iff (!rst_n)
    wr_ok && i_op == op_signed_min && i_sz == 2'h1);
  c_sp: cover property (@(posedge mclk) disable iff (!rst_n) go && d_base == IDX_31);
endmodule : amr_unit
`default_nettype wire

// >>> test/amr_mem_model.sv
/*
 load/store path model: one memory word, programmable ack delay, read fault.
 assumes the unit holds each request until ack and pairs a read with a write.
*/
`timescale 1ns/1ps
`default_nettype none
module amr_mem_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic mem_ord,
  input wire logic mem_lock,
  input wire logic [1:0] mem_size,
  input wire logic [63:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  input wire logic [3:0] delay,
  input wire logic fault_rd,
  input wire logic load,
  input wire logic [63:0] init_word,
  output logic mem_ack,
  output logic mem_fault,
  output logic [63:0] mem_rdata,
  output logic [63:0] word,
  output logic [63:0] rd_addr,
  output logic rd_ord,
  output logic wr_ord,
  output logic pair_err,
  output logic [7:0] acc_cnt
);
  logic [3:0] cnt;
  logic [1:0] rd_size;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {mem_ack, mem_fault, rd_ord, wr_ord, pair_err} <= 5'h00;
      {mem_rdata, word, rd_addr} <= '0;
      {cnt, rd_size, acc_cnt} <= '0;
    end else begin
      mem_ack <= 1'b0;
      mem_fault <= 1'b0;
      // released data does not hold its last value
      mem_rdata <= ~mem_rdata;
      if (load) word <= init_word;
      if (mem_req && !mem_ack) begin
        if (cnt == delay) begin
          cnt <= 4'h0;
          mem_ack <= 1'b1;
          acc_cnt <= acc_cnt + 8'h01;
          if (!mem_wr) begin
            mem_rdata <= word;
            mem_fault <= fault_rd;
            rd_addr <= mem_addr;
            rd_ord <= mem_ord;
            rd_size <= mem_size;
          end else begin
            word <= mem_wdata;
            wr_ord <= mem_ord;
            if (!mem_lock || mem_addr != rd_addr || mem_size != rd_size) begin
              pair_err <= 1'b1;
            end
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule : amr_mem_model
`default_nettype wire

// >>> test/tb.sv
/*
 testbench of the atomic unit: apb master, scenarios, verdict.
 assumes amr_mem_model answers on the load/store port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import amr_pkg::*;
  localparam logic [63:0] M = 64'h8081828384858687;
  localparam logic [63:0] V = 64'h0102030405060708;
  localparam logic [63:0] B = 64'h0000123456789AB0;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, mem_req, mem_wr, mem_ord, mem_lock, mem_ack, mem_fault;
  logic [1:0] mem_size;
  logic [63:0] mem_addr, mem_wdata, mem_rdata, word, rd_addr;
  logic [63:0] init_word = 64'h0;
  logic [3:0] delay = 4'h0;
  logic fault_rd = 1'b0, load = 1'b0, rd_ord, wr_ord, pair_err;
  logic [7:0] acc_cnt;
  int num_errors = 0;
  int samples_checked = 0;
  always #10 mclk = ~mclk;
  amr_unit u_amr_unit (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_wr(mem_wr),
    .mem_ord(mem_ord), .mem_lock(mem_lock), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_fault(mem_fault), .mem_rdata(mem_rdata));
  amr_mem_model u_amr_mem_model (.mclk(mclk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_ord(mem_ord), .mem_lock(mem_lock), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .delay(delay), .fault_rd(fault_rd),
    .load(load), .init_word(init_word), .mem_ack(mem_ack), .mem_fault(mem_fault),
    .mem_rdata(mem_rdata), .word(word), .rd_addr(rd_addr), .rd_ord(rd_ord),
    .wr_ord(wr_ord), .pair_err(pair_err), .acc_cnt(acc_cnt));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task print_verdict;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  function automatic logic [31:0] mk(input logic [1:0] sz, input logic a, input logic r,
      input logic [3:0] sel, input logic [4:0] rn, input logic [4:0] rt);
    return {sz, FIX_HI, a, r, 1'b1, 5'h02, sel, 2'b00, rn, rt};
  endfunction : mk
  // operands shifted to the top so that compares and sums work at access width
  function automatic logic [63:0] res(input logic [3:0] sel, input logic [1:0] sz,
      input logic [63:0] m, input logic [63:0] v);
    int sh;
    logic [63:0] r, ms, vs;
    sh = 64 - (8 << sz);
    ms = m << sh;
    vs = v << sh;
    case (sel)
      4'h0: r = ms + vs;
      4'h1: r = ms & ~vs;
      4'h2: r = ms ^ vs;
      4'h3: r = ms | vs;
      4'h4: r = ($signed(ms) > $signed(vs)) ? ms : vs;
      4'h5: r = ($signed(ms) > $signed(vs)) ? vs : ms;
      4'h6: r = (ms > vs) ? ms : vs;
      4'h7: r = (ms > vs) ? vs : ms;
      default: r = vs;
    endcase
    return r >> sh;
  endfunction : res
  task run(input logic [31:0] ins, input logic [63:0] b, output logic [31:0] st,
           output logic [63:0] d);
    int n;
    init_word <= M;
    load <= 1'b1;
    wr(A_OPLO, V[31:0]);
    load <= 1'b0;
    wr(A_OPHI, V[63:32]);
    wr(A_BSLO, b[31:0]);
    wr(A_BSHI, b[63:32]);
    wr(A_SPLO, b[31:0] ^ 32'h00000100);
    wr(A_SPHI, b[63:32]);
    wr(A_INSTR, ins);
    n = 0;
    do begin
      rd(A_STAT, st);
      n++;
    end while (st[S_BUSY] !== 1'b0 && n < 50);
    rd(A_DLO, d[31:0]);
    rd(A_DHI, d[63:32]);
  endtask : run
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task t_ops;
    logic [31:0] st;
    logic [63:0] d;
    logic [63:0] exp_w;
    for (int sz = 0; sz < 4; sz++) begin
      for (int sel = 0; sel < 9; sel++) begin
        delay <= sel[3:0];
        run(mk(sz[1:0], sel[0], sz[0], sel[3:0], 5'h04, 5'h03), B, st, d);
        exp_w = res(sel[3:0], sz[1:0], M, V);
        check(word, exp_w);
        check(mem_size, sz[1:0]);
        check(d, (M << (64 - (8 << sz))) >> (64 - (8 << sz)));
        check({rd_ord, wr_ord}, {sel[0], sz[0]});
        check(rd_addr, B);
        check({pair_err, st[S_DONE], mem_req, mem_lock}, 4'b0100);
      end
    end
  endtask : t_ops
  task t_special;
    logic [31:0] st;
    logic [63:0] d, d0;
    logic [7:0] c0;
    run(mk(2'h2, 1'b1, 1'b1, 4'h0, 5'h04, 5'h1F), B, st, d);
    check({rd_ord, wr_ord}, 2'b01);
    run(mk(2'h3, 1'b0, 1'b0, 4'h8, 5'h1F, 5'h03), B, st, d0);
    check(rd_addr, B ^ 64'h100);
    c0 = acc_cnt;
    run(mk(2'h3, 1'b0, 1'b0, 4'h8, 5'h1F, 5'h03), B | 64'h4, st, d);
    check({st[S_ALIGN], acc_cnt}, {1'b1, c0});
    for (int sel = 9; sel < 16; sel++) begin
      run(mk(2'h2, 1'b0, 1'b0, sel[3:0], 5'h04, 5'h03), B, st, d);
      check({st[S_UNDEF], acc_cnt}, {1'b1, c0});
    end
    wr(A_CTRL, 32'h0);
    run(mk(2'h2, 1'b0, 1'b0, 4'h0, 5'h04, 5'h03), B, st, d);
    check({st[S_UNDEF], acc_cnt}, {1'b1, c0});
    wr(A_CTRL, 32'h1);
    fault_rd <= 1'b1;
    run(mk(2'h1, 1'b0, 1'b0, 4'h5, 5'h04, 5'h07), B, st, d);
    fault_rd <= 1'b0;
    check(st[S_FAULT], 1'b1);
    check(acc_cnt, c0 + 8'h01);
    check(d, d0);
    check(word, M);
    check({mem_req, mem_lock}, 2'b00);
  endtask : t_special
  task t_regs;
    logic [31:0] q;
    logic e;
    rd(A_CTRL, q);
    check(q, 32'h1);
    rd(A_STAT, q);
    check(q, 32'h0);
    apb(1'b0, 12'h030, 32'h0, q, e);
    check(e, 1'b1);
    apb(1'b0, 12'h002, 32'h0, q, e);
    check(e, 1'b1);
  endtask : t_regs
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_ops();
    t_special();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
